// >>> rtl/vccd_regs.svh
// constants for the visual console command decoder
`ifndef VCCD_REGS_SVH
`define VCCD_REGS_SVH
`define VCCD_DIR_BIT 5
`define VCCD_P1_PLAIN 6'h00
`define VCCD_P1_CR 6'h01
`define VCCD_P1_CRLF 6'h21
`define VCCD_P1_ERASE 6'h22
`define VCCD_P1_ERASE_CRLF 6'h23
`define VCCD_P1_FORM 6'h24
`define VCCD_P1_HOME 6'h38
`define VCCD_DEST_PRN 3'h2
`define VCCD_DEST_INT 3'h4
`define VCCD_DEST_STS 3'h5
`define VCCD_DEST_INT_PRN 3'h0
`define VCCD_DEST_STS_PRN 3'h1
`define VCCD_WIDTH_64 3'h0
`define VCCD_WIDTH_80 3'h4
`define VCCD_COLS_64 7'h40
`define VCCD_COLS_80 7'h50
`define VCCD_LINE_MIN 5'h01
`define VCCD_LINE_MAX 5'h18
`define VCCD_BLINK_CUR 6'h20
`define VCCD_BLINK_BIT 5
`endif

// >>> rtl/vccd_pkg.sv
// types for the visual console command decoder
`default_nettype none
package vccd_pkg;
  typedef struct packed {
    logic [5:0] addr;
    logic [5:0] p1;
    logic [5:0] p2;
    logic [5:0] p3;
  } vccd_cmd_t;
  typedef struct packed {
    logic input_xfer;
    logic cursor_return;
    logic erase_before;
    logic line_feed_after;
    logic clear_screen;
    logic home;
    logic printer_crlf;
    logic sel_printer;
    logic sel_interactive;
    logic sel_status;
    logic [6:0] columns;
    logic goto_line;
    logic [4:0] line;
    logic blink;
  } vccd_act_t;
endpackage
`default_nettype wire

// >>> rtl/vccd_route.sv
// output route and width decode of the second parameter
`timescale 1ns/1ps
`default_nettype none
`include "vccd_regs.svh"
module vccd_route
  import vccd_pkg::*;
(
  input wire logic [5:0] i_p2,
  output logic o_prn,
  output logic o_int,
  output logic o_sts,
  output logic [6:0] o_cols
);
  always_comb begin
    o_prn = 1'b0;
    o_int = 1'b0;
    o_sts = 1'b0;
    unique case (i_p2[2:0])
      `VCCD_DEST_PRN: o_prn = 1'b1;
      `VCCD_DEST_INT: o_int = 1'b1;
      `VCCD_DEST_STS: o_sts = 1'b1;
      `VCCD_DEST_INT_PRN: begin
        o_int = 1'b1;
        o_prn = 1'b1;
      end
      `VCCD_DEST_STS_PRN: begin
        o_sts = 1'b1;
        o_prn = 1'b1;
      end
      default: o_int = 1'b1; // unused codes fall back to the display
    endcase
    // only 0 and 4 are documented; other high digits keep 64
    o_cols = (i_p2[5:3] == `VCCD_WIDTH_80) ? `VCCD_COLS_80 : `VCCD_COLS_64;
  end
endmodule
`default_nettype wire

// >>> rtl/vccd_decoder.sv
// visual console command decoder top
// How it works
// - address high bit one means read
// - address high bit zero means write
// - first param 00 plain, 01 cursor return
// - first param 41 return, line feed after
// - first param 42 erases line first
// - first param 43 erase, then return feed
// - first param 44 clear screen; printer crlf
// - first param 70 homes cursor; printer crlf
// - second param low digit picks outputs
// - second param high digit picks width
// - third param 01-30 goes to line; printer crlf
// - third param 40 blinks cursor line word
// - third param 41-70 goto and blink
// - address io bit: zero out, one in
`timescale 1ns/1ps
`default_nettype none
`include "vccd_regs.svh"
module vccd_decoder
  import vccd_pkg::*;
#(
  parameter int unsigned LAST_LINE = `VCCD_LINE_MAX
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire vccd_cmd_t i_cmd,
  output vccd_act_t o_act,
  output logic o_act_valid
);
  ////////////////////////////////////////////////////////////
  vccd_act_t act_r, act_nxt;
  logic valid_r, valid_nxt;
  logic prn, intr, sts;
  logic [6:0] cols;

  vccd_route u_route (
    .i_p2(i_cmd.p2),
    .o_prn(prn),
    .o_int(intr),
    .o_sts(sts),
    .o_cols(cols)
  );

  // line field is five bits and zero means no move
  if (LAST_LINE < 1 || LAST_LINE > 31) begin : g_bad_last_line
    $error("LAST_LINE must lie between 1 and 31");
  end

  function automatic logic line_ok(input logic [4:0] l);
    line_ok = (l >= `VCCD_LINE_MIN) && (l <= 5'(LAST_LINE));
  endfunction

  ////////////////////////////////////////////////////////////
  always_comb begin
    act_nxt = act_r;
    valid_nxt = 1'b0;
    if (i_cmd_valid) begin
      valid_nxt = 1'b1;
      act_nxt = '0;
      act_nxt.input_xfer = i_cmd.addr[`VCCD_DIR_BIT];
      act_nxt.sel_printer = prn;
      act_nxt.sel_interactive = intr;
      act_nxt.sel_status = sts;
      act_nxt.columns = cols;
      // undocumented first params act as plain transfer
      unique case (i_cmd.p1)
        `VCCD_P1_CR: act_nxt.cursor_return = 1'b1;
        `VCCD_P1_CRLF: begin
          act_nxt.cursor_return = 1'b1;
          act_nxt.line_feed_after = 1'b1;
        end
        `VCCD_P1_ERASE: act_nxt.erase_before = 1'b1;
        `VCCD_P1_ERASE_CRLF: begin
          act_nxt.erase_before = 1'b1;
          act_nxt.cursor_return = 1'b1;
          act_nxt.line_feed_after = 1'b1;
        end
        `VCCD_P1_FORM: begin
          act_nxt.clear_screen = ~prn;
          act_nxt.printer_crlf = prn;
        end
        `VCCD_P1_HOME: begin
          act_nxt.home = ~prn;
          act_nxt.printer_crlf = prn;
        end
        default: ;
      endcase
      if (i_cmd.p3 == `VCCD_BLINK_CUR) begin
        act_nxt.blink = 1'b1;
      end else if (line_ok(i_cmd.p3[4:0])) begin
        // printer has no lines; it gets a crlf instead, unless the blink bit is set, which sends goto and blink
        act_nxt.goto_line = ~prn || i_cmd.p3[`VCCD_BLINK_BIT];
        act_nxt.line = i_cmd.p3[4:0];
        act_nxt.blink = i_cmd.p3[`VCCD_BLINK_BIT];
        if (prn && !i_cmd.p3[`VCCD_BLINK_BIT]) begin
          act_nxt.printer_crlf = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      act_r <= '0;
      valid_r <= 1'b0;
    end else begin
      act_r <= act_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign o_act = act_r;
  assign o_act_valid = valid_r;

  ////////////////////////////////////////////////////////////
  a_dir_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.addr[5] |=> o_act_valid && o_act.input_xfer)
    else $error("read address not decoded as input");
  a_dir_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && !i_cmd.addr[5] |=> !o_act.input_xfer)
    else $error("write address not decoded as output");
  a_plain_xfer: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h00 |=> !o_act.cursor_return && !o_act.erase_before)
    else $error("plain transfer moved cursor");
  a_crlf_after: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h21 |=> o_act.cursor_return && o_act.line_feed_after)
    else $error("code 41 missed line feed");
  a_erase_first: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h22 |=> o_act.erase_before && !o_act.line_feed_after)
    else $error("code 42 wrong");
  a_erase_crlf: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h23 |=> o_act.erase_before && o_act.line_feed_after)
    else $error("code 43 wrong");
  a_form_feed: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h24 |=> (o_act.clear_screen ^ o_act.printer_crlf))
    else $error("form feed wrong");
  a_home_pos: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h38 && i_cmd.p2[2:0] == 3'h4 |=> o_act.home)
    else $error("home not raised");
  a_route_prn: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p2[2:0] == 3'h2 |=> o_act.sel_printer && !o_act.sel_interactive && !o_act.sel_status)
    else $error("printer only route wrong");
  a_width_sel: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p2[5:3] == 3'h4 |=> o_act.columns == 7'h50)
    else $error("80 columns not chosen");
  a_goto_line: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p3 == 6'h18 && i_cmd.p2[2:0] == 3'h4 |=> o_act.goto_line && o_act.line == 5'h18)
    else $error("line 24 not addressed");
  a_blink_cur: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p3 == 6'h20 |=> o_act.blink && !o_act.goto_line)
    else $error("cursor blink wrong");
  a_goto_blink: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p3 == 6'h21 |=> o_act.blink && o_act.goto_line && o_act.line == 5'h01)
    else $error("goto blink wrong");
  a_act_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_cmd_valid |=> $stable(o_act) && !o_act_valid)
    else $error("action changed without command");
  ////////////////////////////////////////////////////////////
  a_route_int: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p2[2:0] == 3'h4 |=> o_act.sel_interactive && !o_act.sel_printer && !o_act.sel_status)
    else $error("display only route wrong");
  a_route_sts: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p2[2:0] == 3'h5 |=> o_act.sel_status && !o_act.sel_printer && !o_act.sel_interactive)
    else $error("status only route wrong");
  a_route_both: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p2[2:0] == 3'h0 |=> o_act.sel_interactive && o_act.sel_printer && !o_act.sel_status)
    else $error("display and printer route wrong");
  a_route_sts_prn: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p2[2:0] == 3'h1 |=> o_act.sel_status && o_act.sel_printer && !o_act.sel_interactive)
    else $error("status and printer route wrong");
  a_route_spare: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p2[2:0] inside {3'h3, 3'h6, 3'h7} |=> o_act.sel_interactive && !o_act.sel_printer)
    else $error("spare route code not sent to display");
  a_width_64: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p2[5:3] == 3'h0 |=> o_act.columns == 7'h40)
    else $error("64 columns not chosen");
  a_width_spare: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && !(i_cmd.p2[5:3] inside {3'h0, 3'h4}) |=> o_act.columns == 7'h40)
    else $error("spare width code not 64 columns");
  a_cr_only: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h01 |=> o_act.cursor_return && !o_act.line_feed_after && !o_act.erase_before)
    else $error("code 01 wrong");
  a_no_erase: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 inside {6'h00, 6'h01, 6'h21, 6'h24, 6'h38} |=> !o_act.erase_before)
    else $error("line erased without erase code");
  a_form_prn: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h24 && i_cmd.p2[2:0] == 3'h2 |=> o_act.printer_crlf && !o_act.clear_screen)
    else $error("printer form feed wrong");
  a_home_prn: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h38 && i_cmd.p2[2:0] == 3'h2 |=> o_act.printer_crlf && !o_act.home)
    else $error("printer home wrong");
  a_unused_p1: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p1 == 6'h3f |=> !o_act.cursor_return && !o_act.erase_before
      && !o_act.line_feed_after && !o_act.clear_screen && !o_act.home)
    else $error("unused first param acted on");
  a_prn_line: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && !i_cmd.p3[5] && i_cmd.p3[4:0] inside {[5'h01:5'h18]} && i_cmd.p2[2:0] == 3'h2 |=>
      o_act.printer_crlf && !o_act.goto_line)
    else $error("printer line code wrong");
  a_line_range: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && !i_cmd.p3[5] && i_cmd.p3[4:0] > 5'h18 |=> !o_act.goto_line && !o_act.blink)
    else $error("line beyond range addressed");
  a_blink_none: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p3 == 6'h00 |=> !o_act.blink && !o_act.goto_line)
    else $error("third param 00 acted on");
  a_blink_goto: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p3 == 6'h38 |=> o_act.blink && o_act.goto_line && o_act.line == 5'h18)
    else $error("goto blink line 24 wrong");
  a_blink_prn: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid && i_cmd.p3 == 6'h21 && i_cmd.p2[2:0] == 3'h2 |=> o_act.blink && o_act.goto_line)
    else $error("printer goto blink wrong");
  a_sel_any: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_act_valid |-> o_act.sel_printer || o_act.sel_interactive || o_act.sel_status)
    else $error("no output selected");
  a_cols_legal: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_act_valid |-> o_act.columns == 7'h40 || o_act.columns == 7'h50)
    else $error("column count not 64 or 80");
  a_valid_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_cmd_valid |=> o_act_valid)
    else $error("command not answered");
endmodule
`default_nettype wire

// >>> verif/vccd_chan_model.sv
// channel-side command source model
`timescale 1ns/1ps
`default_nettype none
module vccd_chan_model
  import vccd_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_go,
  input wire logic i_rd,
  input wire logic [23:0] i_chars,
  output logic o_cmd_valid,
  output vccd_cmd_t o_cmd
);
  // idle chars invert each cycle so stale values never pass for a command
  always_ff @(posedge i_ref_clk) begin
    o_cmd_valid <= i_go;
    o_cmd <= i_go ? {i_rd, i_chars[22:0]} : ~o_cmd;
  end
endmodule
`default_nettype wire

// >>> verif/vccd_decoder_tb.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module vccd_decoder_tb
  import vccd_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  logic rd = 1'b0;
  logic [23:0] chars = 24'h0;
  logic cv;
  vccd_cmd_t cmd;
  vccd_act_t act;
  logic av;
  logic [4:0] p1_seen;
  int miscompares = 0;
  int n_compared = 0;
  logic [5:0] p1c [5] = '{6'h00, 6'h01, 6'h21, 6'h22, 6'h23};
  logic [6:0] p1e [5] = '{7'h00, 7'h10, 7'h14, 7'h08, 7'h1c};
  logic [2:0] dg [5] = '{3'h2, 3'h4, 3'h5, 3'h0, 3'h1};
  logic [6:0] dge [5] = '{7'h04, 7'h02, 7'h01, 7'h06, 7'h05};
  logic [5:0] p3c [4] = '{6'h01, 6'h18, 6'h21, 6'h38};
  logic [6:0] p3e [4] = '{7'h42, 7'h70, 7'h43, 7'h71};
  vccd_chan_model chan_u (.i_ref_clk(clk), .i_go(go), .i_rd(rd), .i_chars(chars), .o_cmd_valid(cv), .o_cmd(cmd));
  vccd_decoder dut_u (.i_ref_clk(clk), .i_rst(rst), .i_cmd_valid(cv), .i_cmd(cmd), .o_act(act), .o_act_valid(av));
  assign p1_seen = {act.cursor_return, act.erase_before, act.line_feed_after, act.clear_screen, act.home};
  initial begin
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // answer is fixed at one cycle, the loop only guards a hang
  task automatic send(input logic r, input logic [5:0] a, b, c);
    int n;
    @(posedge clk);
    go <= 1'b1;
    rd <= r;
    chars <= {6'h07, a, b, c};
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 4 && av !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (av !== 1'b1) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic t_dir;
    send(1'b1, 6'h00, 6'h04, 6'h00);
    chk("input_xfer", 7'h01, 7'(act.input_xfer));
    send(1'b0, 6'h00, 6'h04, 6'h00);
    chk("input_xfer", 7'h00, 7'(act.input_xfer));
  endtask
  task automatic t_p1;
    for (int i = 0; i < 5; i++) begin
      send(1'b0, p1c[i], 6'h04, 6'h00);
      chk("p1", p1e[i], 7'(p1_seen));
    end
    send(1'b0, 6'h24, 6'h04, 6'h00);
    chk("clear", 7'h01, 7'(act.clear_screen));
    send(1'b0, 6'h38, 6'h04, 6'h00);
    chk("home", 7'h01, 7'(act.home));
    send(1'b0, 6'h24, 6'h02, 6'h00);
    chk("prn clear", 7'h02, 7'({act.printer_crlf, act.clear_screen}));
    send(1'b0, 6'h38, 6'h02, 6'h00);
    chk("prn home", 7'h02, 7'({act.printer_crlf, act.home}));
  endtask
  task automatic t_route;
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 5; i++) begin
        send(1'b0, 6'h00, {w[0], 2'b00, dg[i]}, 6'h00);
        chk("route", dge[i], 7'({act.sel_printer, act.sel_interactive, act.sel_status}));
        chk("columns", w ? 7'h50 : 7'h40, act.columns);
      end
    end
    send(1'b0, 6'h00, 6'h17, 6'h00);
    chk("route", 7'h02, 7'({act.sel_printer, act.sel_interactive, act.sel_status}));
    chk("columns", 7'h40, act.columns);
  endtask
  // unused chars carry junk on purpose
  task automatic t_line;
    for (int i = 0; i < 4; i++) begin
      send(1'b0, 6'h3f, 6'h04, p3c[i]);
      chk("line", p3e[i], {act.goto_line, act.line, act.blink});
    end
    send(1'b0, 6'h00, 6'h04, 6'h20);
    chk("blink cur", 7'h01, 7'({act.goto_line, act.blink}));
    send(1'b0, 6'h00, 6'h02, 6'h05);
    chk("prn line", 7'h01, 7'({act.goto_line, act.printer_crlf}));
    send(1'b0, 6'h00, 6'h04, 6'h1f);
    chk("line", 7'h00, {act.goto_line, act.line, act.blink});
    send(1'b0, 6'h00, 6'h02, 6'h21);
    chk("prn blink", 7'h43, {act.goto_line, act.line, act.blink});
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("idle valid", 7'h00, 7'(av));
    t_dir();
    t_p1();
    t_route();
    t_line();
    close_out();
  end
endmodule
`default_nettype wire
